// >>> common/gspc_pkg.sv
// Package: constants and carriers of the gate safety power controller
package gspc_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned STBY_S    = 5;
  localparam int unsigned MENU_S    = 30;
  localparam int unsigned NUDGE_S   = 3;
  localparam int unsigned PAUSE_S   = 10;
  localparam int unsigned TEST_MS   = 20;
  localparam int unsigned STBY_CYC  = STBY_S * CLK_HZ;
  localparam int unsigned MENU_CYC  = MENU_S * CLK_HZ;
  localparam int unsigned NUDGE_CYC = NUDGE_S * CLK_HZ;
  localparam int unsigned PAUSE_CYC = PAUSE_S * CLK_HZ;
  localparam int unsigned TEST_CYC  = TEST_MS * (CLK_HZ / 1000);

  // Resistive edge, codes in steps of 100 ohm
  localparam logic [7:0] EDGE_NOM   = 8'h52;
  localparam logic [7:0] EDGE_TOL   = 8'h0a;
  // Allowed current rise before an obstacle is flagged
  localparam logic [7:0] OBST_MARGIN = 8'h20;

  localparam int unsigned NPIN = 9;

  typedef struct packed {
    logic saving_en;
    logic auto_close_en;
    logic ext_beam_en;
    logic int_beam_en;
    logic fixed_en;
    logic mobile_en;
    logic stop_en;
    logic stop_reverse;
    logic edge_test_setting;
    logic fixed_resistive;
    logic mobile_resistive;
  } gspc_cfg_t;

  // All pins high when idle and safe, except limits and starts
  typedef struct packed {
    logic beam_sensor_input;
    logic int_beam_sensor_input;
    logic fixed_edge_input;
    logic mobile_edge_input;
    logic stop_ok;
    logic open_limit;
    logic close_limit;
    logic start_req;
    logic ped_start_req;
  } gspc_pins_t;

  typedef enum logic [3:0] {
    ST_CLOSED,
    ST_TEST_OFF,
    ST_TEST_ON,
    ST_OPEN,
    ST_CLOSE,
    ST_HALT,
    ST_NUDGE,
    ST_OPENED,
    ST_STOPPED
  } gspc_state_t;

endpackage : gspc_pkg

// >>> rtl/gspc_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module gspc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         nrst,    // Async reset, active low
  input  wire logic [W-1:0] d_in,    // Raw pin levels
  output logic      [W-1:0] q_out    // Synchronised levels
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
        end
        else
        begin
          s1_reg[i] <= d_in[i];
          s2_reg[i] <= s1_reg[i];
        end
      end
    end
  endgenerate

  assign q_out = s2_reg;
endmodule : gspc_sync
`default_nettype wire

// >>> rtl/gspc_top.sv
// Gate safety sequencing, edge handling and energy-saving standby
`timescale 1ns/100ps
`default_nettype none
module gspc_top #(
  parameter int unsigned STBY_CYC  = gspc_pkg::STBY_CYC,
  parameter int unsigned MENU_CYC  = gspc_pkg::MENU_CYC,
  parameter int unsigned NUDGE_CYC = gspc_pkg::NUDGE_CYC,
  parameter int unsigned PAUSE_CYC = gspc_pkg::PAUSE_CYC,
  parameter int unsigned TEST_CYC  = gspc_pkg::TEST_CYC
) (
  input  wire logic               clk_sys,         // 10 MHz clock
  input  wire logic               nrst,            // Async reset
  input  wire gspc_pkg::gspc_cfg_t cfg,            // Settings
  input  wire gspc_pkg::gspc_pins_t pins,          // Raw pins
  input  wire logic [7:0]         motor_current,   // Current code
  input  wire logic [7:0]         fixed_edge_ohm,  // Fixed edge R
  input  wire logic [7:0]         mobile_edge_ohm, // Mobile edge R
  input  wire logic               menu_active,     // Menu open
  output logic                    motor_open,      // Drive opening
  output logic                    motor_close,     // Drive closing
  output logic                    test_supply,     // Tx test supply
  output logic                    accessory_power, // Accessories
  output logic                    display_power,   // Display
  output logic                    flasher_power,   // Flasher
  output logic                    standby,         // Saving mode
  output logic                    fault,           // Test failed
  output logic                    learned          // Travel known
);

  gspc_pkg::gspc_pins_t p;
  logic [gspc_pkg::NPIN-1:0] p_vec;

  gspc_sync #(
    .W (gspc_pkg::NPIN)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (pins),
    .q_out   (p_vec)
  );
  assign p = gspc_pkg::gspc_pins_t'(p_vec);

  gspc_pkg::gspc_state_t st_reg;
  gspc_pkg::gspc_state_t st_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic [31:0] pos_reg;
  logic [31:0] travel_reg;
  logic [31:0] sb_tmr_reg;
  logic [7:0]  base_reg;
  logic        learned_reg;
  logic        from_closed_reg;
  logic        ped_reg;
  logic        ped_next;
  logic        last_open_reg;
  logic        last_open_next;
  logic        estop_reg;
  logic        estop_next;
  logic        nopen_reg;
  logic        nopen_next;
  logic        fault_reg;
  logic        fault_next;
  logic        sb_reg;
  logic        sb_next;
  logic        sb_arm_reg;
  logic        menu_prev_reg;
  logic        start_prev_reg;
  logic        ped_prev_reg;
  logic        mopen_reg;
  logic        mclose_reg;
  logic        test_reg;
  logic        pwr_reg;

  logic       active;
  logic       start_p;
  logic       ped_p;
  logic       cmd;
  logic       fixed_bad;
  logic       mobile_bad;
  logic       ext_trip;
  logic       int_trip;
  logic       fixed_trip;
  logic       mobile_trip;
  logic       stop_trip;
  logic       obst_trip;
  logic       off_ok;
  logic       on_ok;
  logic       tmo;
  logic       ped_done;
  logic       go_open;
  logic       evt_open;
  logic       evt_cycle;
  logic       moving;
  logic [8:0] cur_lim;

  function automatic logic out_of_window(input logic [7:0] code);
    out_of_window = (code < gspc_pkg::EDGE_NOM - gspc_pkg::EDGE_TOL) ||
                    (code > gspc_pkg::EDGE_NOM + gspc_pkg::EDGE_TOL);
  endfunction : out_of_window

  assign active  = !sb_reg;
  assign start_p = p.start_req && !start_prev_reg;
  assign ped_p   = p.ped_start_req && !ped_prev_reg;
  assign cmd     = start_p || ped_p;
  assign tmo     = (tmr_reg == 32'h0);
  assign moving  = mopen_reg || mclose_reg;

  // Edge sensing, contact or resistive
  assign fixed_bad  = cfg.fixed_resistive ?
                      out_of_window(fixed_edge_ohm) :
                      !p.fixed_edge_input;
  assign mobile_bad = cfg.mobile_resistive ?
                      out_of_window(mobile_edge_ohm) :
                      !p.mobile_edge_input;

  assign ext_trip    = cfg.ext_beam_en && !p.beam_sensor_input
                       && active;
  assign int_trip    = cfg.int_beam_en && !p.int_beam_sensor_input
                       && active;
  assign fixed_trip  = cfg.fixed_en && fixed_bad && active;
  assign mobile_trip = cfg.mobile_en && mobile_bad && active;
  assign stop_trip   = cfg.stop_en && !p.stop_ok;

  // Obstacle: current above tracked baseline plus margin
  assign cur_lim   = {1'b0, base_reg} + {1'b0, gspc_pkg::OBST_MARGIN};
  assign obst_trip = moving && ({1'b0, motor_current} > cur_lim);

  // With test supply off, enabled beams, and enabled edges when edge_test_setting is set, must read tripped
  assign off_ok = (!cfg.ext_beam_en || !p.beam_sensor_input) &&
                  (!cfg.int_beam_en || !p.int_beam_sensor_input) &&
                  (!cfg.edge_test_setting ||
                   ((!cfg.fixed_en || fixed_bad) &&
                    (!cfg.mobile_en || mobile_bad)));
  assign on_ok  = !ext_trip && !int_trip &&
                  (!cfg.edge_test_setting ||
                   (!fixed_trip && !mobile_trip));

  assign ped_done = ped_reg && learned_reg &&
                    (pos_reg >= {1'b0, travel_reg[31:1]});

  // Direction of a start from a stopped gate
  always_comb
  begin
    if (estop_reg)
      go_open = (cfg.stop_en && cfg.stop_reverse) ?
                !last_open_reg : last_open_reg;
    else
      go_open = !last_open_reg;
  end

  always_comb
  begin
    st_next        = st_reg;
    tmr_next       = tmo ? tmr_reg : tmr_reg - 32'h1;
    ped_next       = ped_reg;
    last_open_next = last_open_reg;
    estop_next     = estop_reg;
    nopen_next     = nopen_reg;
    fault_next     = fault_reg;
    evt_open       = 1'b0;
    evt_cycle      = 1'b0;
    case (st_reg)
      gspc_pkg::ST_CLOSED:
        if (cmd)
        begin
          ped_next = ped_p;
          st_next  = gspc_pkg::ST_TEST_OFF;
          tmr_next = 32'(TEST_CYC - 1);
        end
      gspc_pkg::ST_TEST_OFF:
        if (tmo)
        begin
          if (off_ok)
          begin
            st_next  = gspc_pkg::ST_TEST_ON;
            tmr_next = 32'(TEST_CYC - 1);
          end
          else
          begin
            st_next    = gspc_pkg::ST_STOPPED;
            fault_next = 1'b1;
          end
        end
      gspc_pkg::ST_TEST_ON:
        if (tmo)
        begin
          if (on_ok)
          begin
            st_next        = gspc_pkg::ST_OPEN;
            fault_next     = 1'b0;
            estop_next     = 1'b0;
            last_open_next = 1'b1;
          end
          else
          begin
            st_next    = gspc_pkg::ST_STOPPED;
            fault_next = 1'b1;
          end
        end
      gspc_pkg::ST_OPEN:
        if (stop_trip || obst_trip)
          st_next = gspc_pkg::ST_STOPPED;
        else if (int_trip)
          st_next = gspc_pkg::ST_HALT;
        else if (mobile_trip)
        begin
          st_next    = gspc_pkg::ST_STOPPED;
          estop_next = 1'b1;
        end
        else if (fixed_trip)
        begin
          st_next    = gspc_pkg::ST_NUDGE;
          nopen_next = 1'b0;
          estop_next = 1'b1;
          tmr_next   = 32'(NUDGE_CYC - 1);
        end
        else if (p.open_limit || ped_done)
        begin
          st_next  = gspc_pkg::ST_OPENED;
          evt_open = 1'b1;
          tmr_next = 32'(PAUSE_CYC - 1);
        end
      gspc_pkg::ST_CLOSE:
        if (stop_trip || obst_trip)
          st_next = gspc_pkg::ST_STOPPED;
        else if (int_trip)
          st_next = gspc_pkg::ST_HALT;
        else if (ext_trip)
        begin
          st_next        = gspc_pkg::ST_OPEN;
          last_open_next = 1'b1;
        end
        else if (fixed_trip)
        begin
          st_next    = gspc_pkg::ST_STOPPED;
          estop_next = 1'b1;
        end
        else if (mobile_trip)
        begin
          st_next    = gspc_pkg::ST_NUDGE;
          nopen_next = 1'b1;
          estop_next = 1'b1;
          tmr_next   = 32'(NUDGE_CYC - 1);
        end
        else if (p.close_limit)
        begin
          st_next   = gspc_pkg::ST_CLOSED;
          evt_cycle = 1'b1;
        end
      gspc_pkg::ST_HALT:
        if (stop_trip)
          st_next = gspc_pkg::ST_STOPPED;
        else if (!int_trip)
        begin
          st_next        = gspc_pkg::ST_OPEN;
          ped_next       = 1'b0;
          last_open_next = 1'b1;
        end
      gspc_pkg::ST_NUDGE:
        if (tmo || stop_trip ||
            (nopen_reg ? p.open_limit : p.close_limit))
          st_next = gspc_pkg::ST_STOPPED;
      gspc_pkg::ST_OPENED:
        if (stop_trip)
          st_next = gspc_pkg::ST_STOPPED;
        else if (cmd || (cfg.auto_close_en && tmo))
        begin
          st_next        = gspc_pkg::ST_CLOSE;
          last_open_next = 1'b0;
        end
      gspc_pkg::ST_STOPPED:
        if (cmd && !stop_trip)
        begin
          if (go_open)
          begin
            ped_next = ped_p;
            st_next  = gspc_pkg::ST_TEST_OFF;
            tmr_next = 32'(TEST_CYC - 1);
          end
          else
          begin
            st_next        = gspc_pkg::ST_CLOSE;
            estop_next     = 1'b0;
            last_open_next = 1'b0;
          end
        end
      default:
        st_next = gspc_pkg::ST_STOPPED;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg        <= gspc_pkg::ST_STOPPED;
      tmr_reg       <= 32'h0;
      ped_reg       <= 1'b0;
      last_open_reg <= 1'b0;
      estop_reg     <= 1'b0;
      nopen_reg     <= 1'b0;
      fault_reg     <= 1'b0;
    end
    else
    begin
      st_reg        <= st_next;
      tmr_reg       <= tmr_next;
      ped_reg       <= ped_next;
      last_open_reg <= last_open_next;
      estop_reg     <= estop_next;
      nopen_reg     <= nopen_next;
      fault_reg     <= fault_next;
    end
  end

  // Motor drive and test supply
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mopen_reg  <= 1'b0;
      mclose_reg <= 1'b0;
      test_reg   <= 1'b0;
    end
    else
    begin
      mopen_reg  <= (st_next == gspc_pkg::ST_OPEN) ||
                    ((st_next == gspc_pkg::ST_NUDGE) && nopen_next);
      mclose_reg <= (st_next == gspc_pkg::ST_CLOSE) ||
                    ((st_next == gspc_pkg::ST_NUDGE) && !nopen_next);
      test_reg   <= (st_next != gspc_pkg::ST_TEST_OFF) && !sb_next;
    end
  end

  // Position tracking and travel learning
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pos_reg         <= 32'h0;
      travel_reg      <= 32'h0;
      learned_reg     <= 1'b0;
      from_closed_reg <= 1'b0;
    end
    else
    begin
      if (p.close_limit)
        pos_reg <= 32'h0;
      else if (mopen_reg && pos_reg != 32'hffffffff)
        pos_reg <= pos_reg + 32'h1;
      else if (mclose_reg && pos_reg != 32'h0)
        pos_reg <= pos_reg - 32'h1;
      if (st_reg == gspc_pkg::ST_CLOSED)
        from_closed_reg <= 1'b1;
      else if (st_next == gspc_pkg::ST_STOPPED ||
               st_next == gspc_pkg::ST_HALT ||
               st_next == gspc_pkg::ST_NUDGE)
        from_closed_reg <= 1'b0;
      if (evt_open && p.open_limit && from_closed_reg && !ped_reg)
      begin
        travel_reg  <= pos_reg;
        learned_reg <= 1'b1;
      end
    end
  end

  // Obstacle baseline follows the current every cycle, held while an obstacle trips
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      base_reg <= 8'h0;
    else if (!moving || !obst_trip)
      base_reg <= motor_current;
  end

  // Command edge detection
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      start_prev_reg <= 1'b0;
      ped_prev_reg   <= 1'b0;
      menu_prev_reg  <= 1'b0;
    end
    else
    begin
      start_prev_reg <= p.start_req;
      ped_prev_reg   <= p.ped_start_req;
      menu_prev_reg  <= menu_active;
    end
  end

  // Standby request
  always_comb
  begin
    if (cmd || menu_active || !cfg.saving_en)
      sb_next = 1'b0;
    else if (sb_arm_reg && sb_tmr_reg == 32'h0)
      sb_next = 1'b1;
    else
      sb_next = sb_reg;
  end

  // Standby timer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sb_reg     <= 1'b0;
      sb_arm_reg <= 1'b0;
      sb_tmr_reg <= 32'h0;
      pwr_reg    <= 1'b1;
    end
    else
    begin
      sb_reg  <= sb_next;
      pwr_reg <= !sb_next;
      if (cmd || menu_active || !cfg.saving_en)
        sb_arm_reg <= 1'b0;
      else if (evt_cycle ||
               (evt_open && !cfg.auto_close_en))
      begin
        sb_arm_reg <= 1'b1;
        sb_tmr_reg <= 32'(STBY_CYC - 1);
      end
      else if (menu_prev_reg && !menu_active)
      begin
        sb_arm_reg <= 1'b1;
        sb_tmr_reg <= 32'(MENU_CYC - 1);
      end
      else if (sb_arm_reg)
      begin
        if (sb_tmr_reg == 32'h0)
          sb_arm_reg <= 1'b0;
        else
          sb_tmr_reg <= sb_tmr_reg - 32'h1;
      end
    end
  end

  assign motor_open      = mopen_reg;
  assign motor_close     = mclose_reg;
  assign test_supply     = test_reg;
  assign accessory_power = pwr_reg;
  assign display_power   = pwr_reg;
  assign flasher_power   = pwr_reg;
  assign standby         = sb_reg;
  assign fault           = fault_reg;
  assign learned         = learned_reg;

endmodule : gspc_top
`default_nettype wire

// >>> test/gate_safety_power_controller_bench.sv
// Self-checking bench for the gate safety power controller
`timescale 1ns/100ps
`default_nettype none
module gate_safety_power_controller_bench;
  localparam int TST = 8;
  localparam int NDG = 16;
  localparam int SBY = 20;
  localparam int MNU = 40;
  logic                 clk_sys = 1'b0;
  logic                 nrst = 1'b0;
  gspc_pkg::gspc_cfg_t  cfg = 11'h5fd;
  gspc_pkg::gspc_pins_t pins;
  logic                 menu_active = 1'b0;
  logic                 st = 1'b0;
  logic                 ped = 1'b0;
  logic                 stop_ok = 1'b1;
  logic [4:0]           flt = 5'h00;
  logic [3:0]           sense;
  logic [7:0]           cur, mob_ohm, fix_ohm;
  logic                 ol, cl, mo, mc, ts, acc, disp, fl;
  logic                 standby, fault, learned;
  logic [6:0]           cv;
  int                   err_count = 0;
  int                   tests_run = 0;

  always #50 clk_sys = ~clk_sys;
  assign pins = {sense, stop_ok, ol, cl, st, ped};
  // Wait codes: 0 open, 1 close, 2 olim, 3 clim, 4 stby, 5 idle, 6 test
  assign cv = {~ts, ~(mo | mc), standby, cl, ol, mc, mo};

  gspc_top #(.STBY_CYC(SBY), .MENU_CYC(MNU), .NUDGE_CYC(NDG),
    .PAUSE_CYC(30), .TEST_CYC(TST)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .pins(pins),
    .motor_current(cur), .fixed_edge_ohm(fix_ohm),
    .mobile_edge_ohm(mob_ohm), .menu_active(menu_active),
    .motor_open(mo), .motor_close(mc), .test_supply(ts),
    .accessory_power(acc), .display_power(disp), .flasher_power(fl),
    .standby(standby), .fault(fault), .learned(learned));
  gspc_gate_model #(.TRAVEL(60)) i_gate (
    .clk_sys(clk_sys), .nrst(nrst), .motor_open(mo), .motor_close(mc),
    .test_supply(ts), .acc_on(acc), .flt(flt), .sense(sense),
    .open_lim(ol), .close_lim(cl), .current(cur), .mob_ohm(mob_ohm),
    .fix_ohm(fix_ohm));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask : chk

  task automatic go(input logic p);
    @(posedge clk_sys);
    st <= ~p;
    ped <= p;
    repeat (3) @(posedge clk_sys);
    st <= 1'b0;
    ped <= 1'b0;
    #1;
  endtask : go

  task automatic wt(input int s, input int n);
    int i;
    i = 0;
    while (cv[s] !== 1'b1 && i < n)
    begin
      cyc(1);
      i++;
    end
    chk(cv[s], 1'b1);
  endtask : wt

  task automatic cnt(input int s, output int n);
    n = 0;
    while (cv[s] === 1'b1 && n < 500)
    begin
      cyc(1);
      n++;
    end
  endtask : cnt

  task automatic t_open_menu;
    int n;
    go(1'b0);
    wt(6, 8);
    cnt(6, n);
    chk(n, TST);
    wt(0, TST + 4);
    wt(2, 100);
    cyc(SBY - 1);
    chk(standby, 1'b0);
    wt(4, 10);
    chk({acc, disp, fl, ts}, 4'h0);
    @(posedge clk_sys) menu_active <= 1'b1;
    cyc(2);
    chk(standby, 1'b0);
    @(posedge clk_sys) menu_active <= 1'b0;
    cyc(MNU - 1);
    chk(standby, 1'b0);
    wt(4, 10);
  endtask : t_open_menu

  task automatic t_cycle;
    @(posedge clk_sys) cfg.saving_en <= 1'b0;
    cyc(8);
    go(1'b0);
    @(posedge clk_sys) cfg.saving_en <= 1'b1;
    wt(3, 100);
    cyc(SBY - 1);
    chk(standby, 1'b0);
    wt(4, 10);
    go(1'b0);
    chk({standby, acc}, 2'h1);
    wt(2, 120);
    cyc(3);
    chk(learned, 1'b1);
    @(posedge clk_sys) cfg.saving_en <= 1'b0;
  endtask : t_cycle

  task automatic t_ext;
    go(1'b0);
    wt(1, 8);
    cyc(10);
    @(posedge clk_sys) flt[4] <= 1'b1;
    wt(0, 6);
    @(posedge clk_sys) flt[4] <= 1'b0;
    wt(2, 100);
    @(posedge clk_sys) cfg.ext_beam_en <= 1'b0;
    go(1'b0);
    wt(1, 8);
    @(posedge clk_sys) flt[4] <= 1'b1;
    cyc(10);
    chk(mc, 1'b1);
    @(posedge clk_sys) flt[4] <= 1'b0;
    cyc(4);
    @(posedge clk_sys) cfg.ext_beam_en <= 1'b1;
    wt(3, 100);
  endtask : t_ext

  task automatic t_edges;
    int n;
    go(1'b0);
    wt(2, 120);
    go(1'b0);
    wt(1, 8);
    cyc(30);
    @(posedge clk_sys) flt[1] <= 1'b1;
    wt(0, 6);
    cnt(0, n);
    chk(n, NDG);
    @(posedge clk_sys) flt[1] <= 1'b0;
    cfg.stop_reverse <= 1'b0;
    cyc(4);
    go(1'b0);
    wt(1, 8);
    wt(3, 100);
    go(1'b0);
    wt(0, 30);
    cyc(30);
    @(posedge clk_sys) flt[2] <= 1'b1;
    wt(1, 6);
    cnt(1, n);
    chk(n, NDG);
    @(posedge clk_sys) flt[2] <= 1'b0;
    cfg.stop_en <= 1'b0;
    cfg.stop_reverse <= 1'b1;
    cyc(4);
    go(1'b0);
    wt(0, 30);
    wt(2, 120);
    @(posedge clk_sys) cfg.stop_en <= 1'b1;
    go(1'b0);
    wt(1, 8);
    cyc(10);
    @(posedge clk_sys) flt[2] <= 1'b1;
    wt(5, 6);
    @(posedge clk_sys) flt[2] <= 1'b0;
    cyc(4);
    go(1'b0);
    wt(0, 30);
    @(posedge clk_sys) flt[1] <= 1'b1;
    wt(5, 6);
    @(posedge clk_sys) flt[1] <= 1'b0;
    cyc(4);
  endtask : t_edges

  task automatic t_halt;
    go(1'b0);
    wt(1, 8);
    cyc(10);
    @(posedge clk_sys) flt[3] <= 1'b1;
    wt(5, 6);
    cyc(10);
    chk(cv[5], 1'b1);
    @(posedge clk_sys) flt[3] <= 1'b0;
    wt(0, 40);
    wt(2, 100);
    go(1'b0);
    wt(1, 8);
    cyc(10);
    @(posedge clk_sys) flt[0] <= 1'b1;
    wt(5, 6);
    @(posedge clk_sys) flt[0] <= 1'b0;
    cyc(4);
    go(1'b0);
    wt(2, 120);
    go(1'b0);
    wt(3, 100);
  endtask : t_halt

  task automatic t_ped_fail;
    go(1'b1);
    wt(0, 30);
    wt(5, 100);
    chk(ol, 1'b0);
    chk(i_gate.pos_reg inside {[25:35]}, 1'b1);
    go(1'b0);
    wt(3, 100);
    @(posedge clk_sys) flt[3] <= 1'b1;
    go(1'b0);
    cyc(2 * TST + 6);
    chk({fault, mo}, 2'h2);
    @(posedge clk_sys) flt[3] <= 1'b0;
    cyc(4);
    go(1'b0);
    wt(0, 30);
    chk(fault, 1'b0);
  endtask : t_ped_fail

  task tally_and_finish;
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    chk({mo, mc, acc, standby, fault, learned}, 6'h08);
    @(posedge clk_sys) nrst <= 1'b1;
    cyc(2);
    t_open_menu;
    t_cycle;
    t_ext;
    t_edges;
    t_halt;
    t_ped_fail;
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    tally_and_finish;
  end
endmodule : gate_safety_power_controller_bench
`default_nettype wire

// >>> test/gspc_gate_model.sv
// Leaves, limit switches, photocells and edges beside the controller
`timescale 1ns/100ps
`default_nettype none
module gspc_gate_model #(
  parameter int unsigned TRAVEL = 60
) (
  input  wire logic       clk_sys,     // Clock
  input  wire logic       nrst,        // Reset, active low
  input  wire logic       motor_open,  // Drive opening
  input  wire logic       motor_close, // Drive closing
  input  wire logic       test_supply, // Tx and edge unit supply
  input  wire logic       acc_on,      // Accessory power
  input  wire logic [4:0] flt,         // Ext, int, fixed, mobile, obstacle
  output logic      [3:0] sense,       // Ext, int, fixed, mobile; 1 clear
  output logic            open_lim,    // Fully open
  output logic            close_lim,   // Fully closed
  output logic      [7:0] current,     // Motor current code
  output logic      [7:0] mob_ohm,     // Mobile edge resistance
  output logic      [7:0] fix_ohm      // Fixed edge resistance
);
  int unsigned pos_reg;
  logic        pwr;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pos_reg <= 0;
    else if (motor_open && pos_reg < TRAVEL)
      pos_reg <= pos_reg + 1;
    else if (motor_close && pos_reg > 0)
      pos_reg <= pos_reg - 1;
  end

  // Sensors dark without test supply or in standby
  assign pwr = test_supply & acc_on;
  assign sense = {4{pwr}} & ~flt[4:1];
  assign open_lim = (pos_reg == TRAVEL);
  assign close_lim = (pos_reg == 0);
  assign current = (flt[0] && (motor_open || motor_close)) ? 8'h70 : 8'h30;
  assign mob_ohm = (flt[1] || !pwr) ? 8'h00 : gspc_pkg::EDGE_NOM;
  assign fix_ohm = (flt[2] || !pwr) ? 8'h00 : gspc_pkg::EDGE_NOM;
endmodule : gspc_gate_model
`default_nettype wire

// >>> test/gspc_top_props.sv
// Port-level assertions for the gate safety power controller
`timescale 1ns/100ps
`default_nettype none
module gspc_top_props (
  input wire logic                 clk_sys,         // Clock
  input wire logic                 nrst,            // Reset, active low
  input wire gspc_pkg::gspc_cfg_t  cfg,             // Settings
  input wire gspc_pkg::gspc_pins_t pins,            // Raw pins
  input wire logic [7:0]           motor_current,   // Current code
  input wire logic [7:0]           fixed_edge_ohm,  // Fixed edge R
  input wire logic [7:0]           mobile_edge_ohm, // Mobile edge R
  input wire logic                 menu_active,     // Menu open
  input wire logic                 motor_open,      // Drive opening
  input wire logic                 motor_close,     // Drive closing
  input wire logic                 test_supply,     // Tx test supply
  input wire logic                 accessory_power, // Accessories
  input wire logic                 display_power,   // Display
  input wire logic                 flasher_power,   // Flasher
  input wire logic                 standby,         // Saving mode
  input wire logic                 fault,           // Test failed
  input wire logic                 learned          // Travel known
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_ext_trip;
    motor_close && cfg.ext_beam_en && !pins.beam_sensor_input &&
    pins.int_beam_sensor_input && pins.stop_ok && pins.fixed_edge_input;
  endsequence
  sequence s_int_trip;
    (motor_open || motor_close) && cfg.int_beam_en &&
    !pins.int_beam_sensor_input;
  endsequence
  sequence s_mob_close;
    motor_close && cfg.mobile_en && cfg.mobile_resistive &&
    mobile_edge_ohm < 8'h48 && pins.int_beam_sensor_input && pins.stop_ok;
  endsequence
  sequence s_fix_open;
    motor_open && cfg.fixed_en && !cfg.fixed_resistive &&
    !pins.fixed_edge_input && pins.int_beam_sensor_input && pins.stop_ok;
  endsequence

  a_power_cut: assert property (
    standby |-> !accessory_power && !display_power && !flasher_power)
    else $error("Accessory power on during standby");
  a_standby_tx_off: assert property (
    standby |-> !test_supply)
    else $error("Test supply on during standby");
  a_standby_idle: assert property (
    $rose(standby) |-> cfg.saving_en && !motor_open && !motor_close)
    else $error("Standby entered while moving or saving off");
  a_saving_off_wake: assert property (
    !cfg.saving_en |=> !standby)
    else $error("Standby held with saving off");
  a_menu_wake: assert property (
    menu_active |=> !standby)
    else $error("Standby held with menu open");
  a_start_wake: assert property (
    $rose(pins.start_req) |-> ##[1:4] !standby)
    else $error("Start did not leave standby");
  a_ext_reverse: assert property (
    s_ext_trip [*3] |-> ##[1:2] motor_open && !motor_close)
    else $error("Exterior beam did not reverse closing");
  a_int_halt: assert property (
    s_int_trip [*3] |-> ##[1:2] !motor_open && !motor_close)
    else $error("Interior beam did not halt leaves");
  a_mobile_close_rev: assert property (
    s_mob_close |-> ##[1:2] motor_open && !motor_close)
    else $error("Mobile edge did not reverse closing");
  a_fixed_open_back: assert property (
    s_fix_open [*3] |-> ##[1:2] motor_close && !motor_open)
    else $error("Fixed edge did not drive back while opening");
endmodule : gspc_top_props

bind gspc_top gspc_top_props i_props (
  .clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .pins(pins),
  .motor_current(motor_current), .fixed_edge_ohm(fixed_edge_ohm),
  .mobile_edge_ohm(mobile_edge_ohm), .menu_active(menu_active),
  .motor_open(motor_open), .motor_close(motor_close),
  .test_supply(test_supply), .accessory_power(accessory_power),
  .display_power(display_power), .flasher_power(flasher_power),
  .standby(standby), .fault(fault), .learned(learned)
);
`default_nettype wire
